// ==== hw/tmrb_pkg.sv ====
// Constants for the temperature monitor register bank
package tmrb_pkg;
  // Register offsets as seen by the pointer
  localparam logic [7:0] ADDR_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] ADDR_REMOTE_HIGH = 8'h01;
  localparam logic [7:0] ADDR_CONFIG_RD = 8'h03;
  localparam logic [7:0] ADDR_RATE_RD = 8'h04;
  localparam logic [7:0] ADDR_CONFIG_WR = 8'h09;
  localparam logic [7:0] ADDR_RATE_WR = 8'h0A;
  localparam logic [7:0] ADDR_REMOTE_LOW = 8'h10;
  // General storage (limits and the like) occupies LIMIT_BASE .. LIMIT_BASE+LIMIT_COUNT-1
  localparam logic [7:0] ADDR_LIMIT_BASE = 8'h30;
  localparam int LIMIT_COUNT = 15;
  // Reset values
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h08;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  // Configuration field positions
  localparam int CFG_ALARM_MASK_BIT = 7;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CFG_PIN6_FUNCTION_SELECT = 5;
  localparam int CFG_RANGE_BIT = 2;
  // Rate code limits
  localparam logic [3:0] RATE_CODE_MAX = 4'hA;
  // Temperature encoding
  localparam int TEMP_W = 10;
  localparam logic signed [TEMP_W-1:0] BINARY_MAX = 10'sd127;
  localparam logic signed [TEMP_W-1:0] OFFSET_BIAS = 10'sd64;
  localparam logic signed [TEMP_W-1:0] OFFSET_MAX = 10'sd255;
  // Fastest conversion interval: 15.625 ms at 64 per second
  localparam int CLK_MHZ = 100;
  localparam int FAST_INTERVAL_US = 15625;
  localparam int FAST_INTERVAL_CYCLES = FAST_INTERVAL_US * CLK_MHZ;
endpackage

// ==== hw/tmrb_register_bank.sv ====
// Register bank, result formatting and conversion pacing of a temperature monitor
`timescale 1ns/1ps
// Notes on behaviour
// - Default range stores results as plain binary, zero to 127 degrees.
// - Extended range stores results as temperature plus 64 (offset binary).
// - Plain binary saturates: below zero gives 0, above 127 gives 127.
// - Range may change anytime; the next stored result uses the new format.
// - Range changes never touch stored limit registers.
// - Twenty-one eight-bit registers, pointer included, hold results, limits and controls.
// - First byte of each bus write loads the pointer.
// - Second write byte goes to pointed register; reads return pointed register.
// - Pointer resets to zero, so an early read returns local temperature.
// - Value registers written only by converter, readable, reset to zero.
// - Configuration read at one address, written at another, resets zero.
// - Alarm mask bit disables alarm output; ignored when pin six is second output.
// - Standby bit stops conversions; clear keeps converter running.
// - In standby bus and alarm outputs stay live and follow register writes.
// - Pin six function bit selects alarm output or second overtemperature output.
// - Range bit selects default or extended range.
// - Rate register read and written at separate addresses, resets to eight.
// - Low rate bits divide oscillator by powers of two up to 1024.
// - Each rate interval starts conversion of both channels.
// - Remote low byte uses two top bits for quarter degrees; rest zero.
module tmrb_register_bank
#(
  parameter int FAST_CYCLES = tmrb_pkg::FAST_INTERVAL_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic busWrValid,
  input wire logic busWrFirst,
  input wire logic [7:0] busWrData,
  input wire logic busRdReq,
  output logic [7:0] busRdData,
  output logic busRdValid,
  output logic convStart,
  input wire logic convDone,
  input wire logic signed [tmrb_pkg::TEMP_W-1:0] convLocalTemp,
  input wire logic signed [tmrb_pkg::TEMP_W-1:0] convRemoteTemp,
  input wire logic [1:0] convRemoteFrac,
  input wire logic alertLatched,
  input wire logic remoteHighTrip,
  input wire logic localHighTrip,
  output logic pin6OutN,
  output logic standbyActive,
  output logic rangeExtended
);
  import tmrb_pkg::*;

  // One-cycle interval would merge start pulses; the slowest shift must fit 32 bits
  if (FAST_CYCLES < 2 || FAST_CYCLES > 32'h0020_0000)
  begin : g_bad_fast_cycles
    $error("FAST_CYCLES out of range");
  end

  logic rstSync1;
  logic rstSync2;
  logic [7:0] pointerReg;
  logic [7:0] configReg;
  logic [7:0] rateReg;
  logic [7:0] localValueReg;
  logic [7:0] remoteHighReg;
  logic [7:0] remoteLowReg;
  logic [7:0] limitMem [LIMIT_COUNT];
  logic [31:0] rateCountReg;
  logic [31:0] intervalCycles;
  logic [3:0] rateCode;
  logic limitHit;
  logic [7:0] limitIdx;
  logic [7:0] readMux;

  // Result encoder shared by both channels
  function automatic logic [7:0] fmtTemp(input logic signed [TEMP_W-1:0] t, input logic ext);
    logic signed [TEMP_W:0] biased;
    biased = {t[TEMP_W-1], t} + {OFFSET_BIAS[TEMP_W-1], OFFSET_BIAS}; // One spare bit so hot inputs cannot wrap
    if (!ext)
    begin
      if (t < 0)
        return 8'h00;
      else if (t > BINARY_MAX)
        return BINARY_MAX[7:0];
      else
        return t[7:0];
    end
    else
    begin
      if (biased < 0)
        return 8'h00;
      else if (biased > OFFSET_MAX)
        return OFFSET_MAX[7:0];
      else
        return biased[7:0];
    end
  endfunction

  // Reset release through two flops so removal is clean
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  // Pointer takes the first byte of every write
  always_ff @(posedge core_clk or negedge rstSync2)
  begin
    if (!rstSync2)
      pointerReg <= POINTER_RESET;
    else if (busWrValid && busWrFirst)
      pointerReg <= busWrData;
  end

  // Storage lookup for the general limit block
  always_comb
  begin
    limitIdx = pointerReg - ADDR_LIMIT_BASE;
    limitHit = (pointerReg >= ADDR_LIMIT_BASE) && (limitIdx < 8'(LIMIT_COUNT));
  end

  // Configuration and rate write ports; read-only aliases fall through
  always_ff @(posedge core_clk or negedge rstSync2)
  begin
    if (!rstSync2)
    begin
      configReg <= CONFIG_RESET;
      rateReg <= RATE_RESET;
    end
    else if (busWrValid && !busWrFirst)
    begin
      if (pointerReg == ADDR_CONFIG_WR)
        configReg <= busWrData;
      else if (pointerReg == ADDR_RATE_WR)
        rateReg <= busWrData;
      // Writes at 0x00/0x01/0x03/0x04/0x10 land nowhere
    end
  end

  // Limits are plain storage; the range bit never reaches them
  always_ff @(posedge core_clk or negedge rstSync2)
  begin
    if (!rstSync2)
    begin
      for (int i = 0; i < LIMIT_COUNT; i++)
        limitMem[i] <= VALUE_RESET;
    end
    else if (busWrValid && !busWrFirst && limitHit)
      limitMem[limitIdx[3:0]] <= busWrData;
  end

  // Converter results, formatted with the range in force at capture
  always_ff @(posedge core_clk or negedge rstSync2)
  begin
    if (!rstSync2)
    begin
      localValueReg <= VALUE_RESET;
      remoteHighReg <= VALUE_RESET;
      remoteLowReg <= VALUE_RESET;
    end
    else if (convDone)
    begin
      localValueReg <= fmtTemp(convLocalTemp, configReg[CFG_RANGE_BIT]);
      remoteHighReg <= fmtTemp(convRemoteTemp, configReg[CFG_RANGE_BIT]);
      remoteLowReg <= {convRemoteFrac, 6'b00_0000};
    end
  end

  // Reserved rate codes run at the fastest rate rather than hang
  always_comb
  begin
    rateCode = (rateReg[3:0] > RATE_CODE_MAX) ? RATE_CODE_MAX : rateReg[3:0];
    intervalCycles = 32'(FAST_CYCLES) << (RATE_CODE_MAX - rateCode);
  end

  // Interval timer; standby parks it and suppresses starts
  always_ff @(posedge core_clk or negedge rstSync2)
  begin
    if (!rstSync2)
    begin
      rateCountReg <= 32'h0000_0000;
      convStart <= 1'b0;
    end
    else if (configReg[CFG_STANDBY_BIT])
    begin
      rateCountReg <= 32'h0000_0000;
      convStart <= 1'b0;
    end
    else if (rateCountReg >= intervalCycles - 32'h0000_0001)
    begin
      rateCountReg <= 32'h0000_0000;
      convStart <= 1'b1;
    end
    else
    begin
      rateCountReg <= rateCountReg + 32'h0000_0001;
      convStart <= 1'b0;
    end
  end

  // Read multiplexer on the stored pointer
  always_comb
  begin
    readMux = 8'h00;
    if (limitHit)
      readMux = limitMem[limitIdx[3:0]];
    else
    begin
      unique case (pointerReg)
        ADDR_LOCAL_TEMP: readMux = localValueReg;
        ADDR_REMOTE_HIGH: readMux = remoteHighReg;
        ADDR_REMOTE_LOW: readMux = remoteLowReg;
        ADDR_CONFIG_RD: readMux = configReg;
        ADDR_RATE_RD: readMux = rateReg;
        default: readMux = 8'h00;
      endcase
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge core_clk or negedge rstSync2)
  begin
    if (!rstSync2)
    begin
      busRdData <= 8'h00;
      busRdValid <= 1'b0;
    end
    else
    begin
      busRdValid <= busRdReq;
      if (busRdReq)
        busRdData <= readMux;
    end
  end

  // Pin six and mode outputs keep running in standby
  always_ff @(posedge core_clk or negedge rstSync2)
  begin
    if (!rstSync2)
    begin
      pin6OutN <= 1'b1;
      standbyActive <= 1'b0;
      rangeExtended <= 1'b0;
    end
    else
    begin
      standbyActive <= configReg[CFG_STANDBY_BIT];
      rangeExtended <= configReg[CFG_RANGE_BIT];
      if (configReg[CFG_PIN6_FUNCTION_SELECT])
        pin6OutN <= !(localHighTrip || remoteHighTrip);
      else
        pin6OutN <= !(alertLatched && !configReg[CFG_ALARM_MASK_BIT]);
    end
  end

  // Checks
  property p_ptr_load;
    @(posedge core_clk) disable iff (!rstSync2)
    busWrValid && busWrFirst |=> pointerReg == $past(busWrData);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_cfg_write;
    @(posedge core_clk) disable iff (!rstSync2)
    busWrValid && !busWrFirst && pointerReg == ADDR_CONFIG_WR |=> configReg == $past(busWrData);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_alias_ignored;
    @(posedge core_clk) disable iff (!rstSync2)
    busWrValid && !busWrFirst && (pointerReg == ADDR_CONFIG_RD || pointerReg == ADDR_RATE_RD)
      |=> $stable(configReg) && $stable(rateReg);
  endproperty
  a_alias_ignored: assert property (p_alias_ignored) else $error("alias write changed a register");

  property p_read_ret;
    @(posedge core_clk) disable iff (!rstSync2)
    busRdReq |=> busRdValid && busRdData == $past(readMux);
  endproperty
  a_read_ret: assert property (p_read_ret) else $error("read data wrong");

  property p_binary_sat;
    @(posedge core_clk) disable iff (!rstSync2)
    convDone && !configReg[CFG_RANGE_BIT] |=> localValueReg <= 8'h7F;
  endproperty
  a_binary_sat: assert property (p_binary_sat) else $error("binary result above 127");

  property p_offset_fmt;
    @(posedge core_clk) disable iff (!rstSync2)
    convDone && configReg[CFG_RANGE_BIT] && convLocalTemp == 10'sd0 |=> localValueReg == 8'h40;
  endproperty
  a_offset_fmt: assert property (p_offset_fmt) else $error("offset code wrong");

  property p_low_byte;
    @(posedge core_clk) disable iff (!rstSync2)
    remoteLowReg[5:0] == 6'b00_0000;
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte spare bits set");

  property p_standby_quiet;
    @(posedge core_clk) disable iff (!rstSync2)
    configReg[CFG_STANDBY_BIT] |=> !convStart;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("conversion in standby");

  property p_start_spacing;
    @(posedge core_clk) disable iff (!rstSync2)
    convStart |=> !convStart;
  endproperty
  a_start_spacing: assert property (p_start_spacing) else $error("starts too close");

  property p_mask;
    @(posedge core_clk) disable iff (!rstSync2)
    !configReg[CFG_PIN6_FUNCTION_SELECT] && configReg[CFG_ALARM_MASK_BIT]
      && $stable(configReg) |=> pin6OutN;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alarm asserted");

  c_start: cover property (@(posedge core_clk) disable iff (!rstSync2) convStart);
  c_ext_capture: cover property (@(posedge core_clk) disable iff (!rstSync2)
    convDone && configReg[CFG_RANGE_BIT]);
  c_second_out: cover property (@(posedge core_clk) disable iff (!rstSync2)
    configReg[CFG_PIN6_FUNCTION_SELECT] && !pin6OutN);
endmodule // tmrb_register_bank

// ==== testbench/tmrb_host_model.sv ====
// Bus engine model: pointer writes, data writes and reads
`timescale 1ns/1ps
module tmrb_host_model
(
  input wire logic core_clk,
  output logic busWrValid,
  output logic busWrFirst,
  output logic [7:0] busWrData,
  output logic busRdReq,
  input wire logic [7:0] busRdData,
  input wire logic busRdValid
);
  // Idle from time zero
  initial
  begin
    busWrValid = 1'b0;
    busWrFirst = 1'b0;
    busWrData = 8'h00;
    busRdReq = 1'b0;
  end
  // Pointer byte, then an optional data byte
  task automatic wrReg(input logic [7:0] addr, input logic [7:0] data, input bit withData);
    @(negedge core_clk);
    busWrValid = 1'b1;
    busWrFirst = 1'b1;
    busWrData = addr;
    if (withData)
    begin
      @(negedge core_clk);
      busWrFirst = 1'b0;
      busWrData = data;
    end
    @(negedge core_clk);
    busWrValid = 1'b0;
    busWrFirst = 1'b0;
    busWrData = ~busWrData; // Stale byte inverted, never looks live
  endtask
  // Read of the pointed register, bounded wait for the answer
  task automatic rdReg(output logic [7:0] data, output bit ok);
    int n;
    @(negedge core_clk);
    busRdReq = 1'b1;
    @(negedge core_clk);
    busRdReq = 1'b0;
    ok = 1'b0;
    data = 8'h00;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (busRdValid === 1'b1)
      begin
        ok = 1'b1;
        data = busRdData;
      end
      else
        @(negedge core_clk);
    end
  endtask
endmodule // tmrb_host_model

// ==== testbench/tmrb_register_bank_bench.sv ====
// Self-checking bench of the register bank
`timescale 1ns/1ps
module tmrb_register_bank_bench;
  import tmrb_pkg::*;
  logic core_clk, rst_n, busWrValid, busWrFirst, busRdReq, busRdValid, convStart, convDone;
  logic [7:0] busWrData, busRdData, cfg;
  logic signed [TEMP_W-1:0] convLocalTemp, convRemoteTemp;
  logic [1:0] convRemoteFrac;
  logic alertLatched, remoteHighTrip, localHighTrip, pin6OutN, standbyActive, rangeExtended;
  int err_total, tests_run, seed, i, n, t;
  int corner[10] = '{-64, -55, 1, 0, 127, 128, 150, 300, 200, -100};
  logic [7:0] rAddr[7] = '{8'h01, 8'h10, 8'h03, 8'h04, 8'h09, 8'h0A, 8'h30};
  logic [7:0] rExp[7] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
  int rates[3] = '{10, 20, 40};

  tmrb_register_bank #(.FAST_CYCLES(10)) u_tmrb_register_bank (.core_clk(core_clk), .rst_n(rst_n),
    .busWrValid(busWrValid), .busWrFirst(busWrFirst), .busWrData(busWrData), .busRdReq(busRdReq),
    .busRdData(busRdData), .busRdValid(busRdValid), .convStart(convStart), .convDone(convDone),
    .convLocalTemp(convLocalTemp), .convRemoteTemp(convRemoteTemp), .convRemoteFrac(convRemoteFrac),
    .alertLatched(alertLatched), .remoteHighTrip(remoteHighTrip), .localHighTrip(localHighTrip),
    .pin6OutN(pin6OutN), .standbyActive(standbyActive), .rangeExtended(rangeExtended));
  tmrb_host_model u_tmrb_host_model (.core_clk(core_clk), .busWrValid(busWrValid),
    .busWrFirst(busWrFirst), .busWrData(busWrData), .busRdReq(busRdReq), .busRdData(busRdData),
    .busRdValid(busRdValid));

  // 100 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Expected stored code for a whole-degree temperature
  function automatic logic [7:0] fmt(input int tv, input bit ext);
    int v;
    v = ext ? tv + 64 : tv;
    if (v < 0) v = 0;
    if (v > (ext ? 255 : 127)) v = ext ? 255 : 127;
    return v[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Optional pointer write, then read and compare
  task automatic rdAt(input logic [7:0] a, input logic [7:0] exp, input bit setPtr);
    logic [7:0] d;
    bit ok;
    if (setPtr) u_tmrb_host_model.wrReg(a, 8'h00, 1'b0);
    u_tmrb_host_model.rdReg(d, ok);
    if (!ok)
    begin
      chk(8'hEE, 8'h00, "read timeout");
      tally_and_finish();
    end
    chk(d, exp, $sformatf("read %h", a));
  endtask
  // Counts cycles to the next start pulse; a bound that runs out ends the run
  task automatic waitStart(output int k);
    k = 0;
    do
    begin
      @(negedge core_clk);
      k++;
    end
    while (convStart !== 1'b1 && k < 20000);
    if (k >= 20000)
    begin
      chk(8'hEE, 8'h00, "no start");
      tally_and_finish();
    end
  endtask
  task automatic conv(input int lt, input int rt, input logic [1:0] fr);
    @(negedge core_clk);
    convDone = 1'b1;
    convLocalTemp = lt[TEMP_W-1:0];
    convRemoteTemp = rt[TEMP_W-1:0];
    convRemoteFrac = fr;
    @(negedge core_clk);
    convDone = 1'b0;
  endtask

  // Main sequence
  initial
  begin
    err_total = 0;
    tests_run = 0;
    seed = 32'hef26;
    rst_n = 1'b0;
    {convDone, convLocalTemp, convRemoteTemp, convRemoteFrac} = '0;
    {alertLatched, remoteHighTrip, localHighTrip} = 3'b000;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    rdAt(8'h00, 8'h00, 1'b0);
    for (i = 0; i < 7; i++) rdAt(rAddr[i], rExp[i], 1'b1);
    $display("Test reset values done");
    u_tmrb_host_model.wrReg(8'h00, 8'h5A, 1'b1);
    rdAt(8'h00, 8'h00, 1'b1);
    u_tmrb_host_model.wrReg(8'h03, 8'h44, 1'b1);
    rdAt(8'h03, 8'h00, 1'b1);
    u_tmrb_host_model.wrReg(8'h04, 8'h03, 1'b1);
    rdAt(8'h04, 8'h08, 1'b1);
    u_tmrb_host_model.wrReg(8'h09, 8'hA4, 1'b1);
    rdAt(8'h03, 8'hA4, 1'b1);
    chk({7'd0, rangeExtended}, 8'h01, "range flag");
    u_tmrb_host_model.wrReg(8'h30, 8'h5A, 1'b1);
    $display("Test write paths done");
    // Range flips before every result; limit must survive each flip
    for (i = 0; i < 24; i++)
    begin
      t = (i < 10) ? corner[i] : ($random(seed) % 160) + 60;
      cfg = i[0] ? 8'h04 : 8'h00;
      u_tmrb_host_model.wrReg(8'h09, cfg, 1'b1);
      conv(t, t + 1, i[2:1]);
      rdAt(8'h00, fmt(t, i[0]), 1'b1);
      rdAt(8'h01, fmt(t + 1, i[0]), 1'b1);
      rdAt(8'h10, {i[2:1], 6'd0}, 1'b1);
      rdAt(8'h30, 8'h5A, 1'b1);
    end
    // Extended range is in force now; host rewrites the limit as 10 degrees offset binary
    u_tmrb_host_model.wrReg(8'h30, fmt(10, 1'b1), 1'b1);
    rdAt(8'h30, 8'h4A, 1'b1);
    $display("Test formats done");
    // Rates 0x0A, 0x09, 0x08 only; reserved codes never sent
    for (i = 0; i < 3; i++)
    begin
      u_tmrb_host_model.wrReg(8'h0A, 8'h0A - i[7:0], 1'b1);
      rdAt(8'h04, 8'h0A - i[7:0], 1'b1);
      waitStart(n);
      waitStart(n);
      waitStart(n);
      chk(n[7:0], rates[i][7:0], "interval");
    end
    $display("Test rates done");
    u_tmrb_host_model.wrReg(8'h09, 8'h40, 1'b1);
    @(negedge core_clk);
    chk({7'd0, standbyActive}, 8'h01, "standby flag");
    n = 0;
    repeat (300)
    begin
      @(negedge core_clk);
      if (convStart !== 1'b0) n++;
    end
    chk(n[7:0], 8'h00, "start in standby");
    // Pin six for every mode, mask, alarm and remote trip mix, local trip random, all in standby
    for (i = 0; i < 16; i++)
    begin
      {alertLatched, remoteHighTrip, localHighTrip} = {i[2], i[3], $random(seed) % 2 == 0};
      u_tmrb_host_model.wrReg(8'h09, 8'h40 | (i[0] ? 8'h20 : 8'h00) | (i[1] ? 8'h80 : 8'h00), 1'b1);
      repeat (2) @(negedge core_clk);
      chk({7'd0, pin6OutN}, {7'd0, i[0] ? !(remoteHighTrip | localHighTrip) : !(alertLatched & !i[1])},
        "pin six");
    end
    $display("Test standby and pin six done");
    u_tmrb_host_model.wrReg(8'h09, 8'h00, 1'b1);
    waitStart(n);
    chk({7'd0, standbyActive}, 8'h00, "run again");
    $display("Test resume done");
    tally_and_finish();
  end
endmodule // tmrb_register_bank_bench
